/* File: core/cicr_pkg.sv */
// Shared constants and types of the multichannel CIC rate-change filter.
// Assumes one master clock; included by the filter and by the bench.
package cicr_pkg;

    // ==================================================================
    // Build limits and defaults
    localparam int RATE_W           = 11;
    localparam int DIR_DECIMATE     = 0;
    localparam int DIR_INTERPOLATE  = 1;
    localparam int SLOTS_MIN        = 1;
    localparam int SLOTS_MAX        = 64;
    localparam int SLOTS_DEF        = 1;
    localparam int IF_MIN           = 1;
    localparam int IF_MAX           = 32;
    localparam int IF_DEF           = 1;
    localparam int CHAN_MAX         = 64;
    localparam int MEM_LIMIT_MAX    = 1024;
    localparam int MEM_LIMIT_DEF    = 0;
    localparam int DIN_W_DEF        = 18;
    localparam int DOUT_W_DEF       = 18;
    localparam int STAGES_DEF       = 4;
    localparam int RATE_DEF         = 4;
    localparam int RATE_MIN         = 2;
    localparam int RATE_MAX_DEF     = 5;
    localparam int RATE_LIMIT       = 1024;
    localparam int LARGE_MEM_EXTRA  = 1;

    // ==================================================================
    // Types
    typedef enum logic [1:0]
    {
        CICR_ST_CLEAR = 2'b01,
        CICR_ST_RUN   = 2'b10
    } cicr_state_t;

    typedef struct packed
    {
        logic              we;
        logic [RATE_W-1:0] value;
    } cicr_rate_cfg_t;

endpackage

/* File: core/cicr_filter.sv */
// Multichannel CIC decimator or interpolator with time-shared slots.
// Assumes inputs synchronous to core_clk and a source that obeys the strobes.
`timescale 1ns/1ps
`default_nettype none

module cicr_filter
#(
    parameter int FILTER_DIRECTION      = cicr_pkg::DIR_DECIMATE,
    parameter int IF_NUM                = cicr_pkg::IF_DEF,
    parameter int SLOTS                 = cicr_pkg::SLOTS_DEF,
    parameter int DIN_W                 = cicr_pkg::DIN_W_DEF,
    parameter int DOUT_W                = cicr_pkg::DOUT_W_DEF,
    parameter int STAGES                = cicr_pkg::STAGES_DEF,
    parameter int R_RATE                = cicr_pkg::RATE_DEF,
    parameter int VAR_RATE              = 0,
    parameter int VAR_R_MAX             = cicr_pkg::RATE_MAX_DEF,
    parameter int RAM_PERMIT            = 0,
    parameter int SMALL_MEM_DEPTH_LIMIT = cicr_pkg::MEM_LIMIT_DEF,
    parameter int USE_STROBE            = 1,
    parameter int USE_EARLY_READY       = 1,
    localparam int IN_LANES  = (FILTER_DIRECTION == cicr_pkg::DIR_INTERPOLATE) ? 1 : IF_NUM,
    localparam int OUT_LANES = (FILTER_DIRECTION == cicr_pkg::DIR_INTERPOLATE) ? IF_NUM : 1
)
(
    // Clock and resets
    input  wire logic                              core_clk,
    input  wire logic                              rst_b,
    input  wire logic                              sync_rst,
    // Sample input
    input  wire logic [DIN_W*IN_LANES-1:0]         din,
    input  wire logic                              din_strobe,
    input  wire logic                              first_slot_mark_in,
    output logic                                   source_ready,
    output logic                                   ready_early_pulse,
    // Sample output
    output logic [DOUT_W*OUT_LANES-1:0]            dout,
    output logic [OUT_LANES-1:0]                   dout_valid,
    // Runtime rate factor
    input  wire cicr_pkg::cicr_rate_cfg_t          rate_cfg
);
    import cicr_pkg::*;

    // ==================================================================
    // Derived sizes
    // direction select
    localparam bit IS_INT    = (FILTER_DIRECTION == DIR_INTERPOLATE);
    localparam int CH        = IF_NUM * SLOTS;
    localparam int CW        = (CH > 1) ? $clog2(CH) : 1;
    localparam int RMAX      = (VAR_RATE == 1) ? VAR_R_MAX : R_RATE;
    localparam int W         = DIN_W + STAGES * $clog2(RMAX);
    localparam bit USE_MEM   = (RAM_PERMIT == 1);
    // small or large blocks by depth
    localparam bit MEM_SMALL = (CH <= SMALL_MEM_DEPTH_LIMIT);
    // clear stretched to one entry per cycle for memories
    localparam int CLR_LEN   = !USE_MEM ? 1 : (MEM_SMALL ? CH : CH + LARGE_MEM_EXTRA);
    localparam int CLR_W     = $clog2(CLR_LEN + 1);
    localparam logic [CLR_W-1:0]  CLR_LAST = CLR_W'(CLR_LEN - 1);
    localparam logic [RATE_W-1:0] RATE_RST = RATE_W'(R_RATE);

    // ==================================================================
    // Build checks
    // slot, interface, channel, rate, memory and width ranges
    generate
        if (SLOTS < SLOTS_MIN || SLOTS > SLOTS_MAX || IF_NUM < IF_MIN || IF_NUM > IF_MAX
            || CH > CHAN_MAX || R_RATE < RATE_MIN || RMAX > RATE_LIMIT || IF_NUM > R_RATE
            || SMALL_MEM_DEPTH_LIMIT > MEM_LIMIT_MAX || DOUT_W > W || STAGES < 1)
        begin : g_bad_config
            $error("cicr_filter: unsupported parameter combination");
        end
    endgenerate

    // ==================================================================
    // State
    typedef struct packed
    {
        cicr_state_t                        st;
        logic [CLR_W-1:0]                   clr;
        logic [RATE_W-1:0]                  rate;
        logic [RATE_W-1:0]                  rate_new;
        logic [RATE_W-1:0]                  phase;
        logic [CW-1:0]                      ch;
        logic [CW-1:0]                      ptr;
        logic                               ready;
        logic                               early;
        logic [CH-1:0][STAGES-1:0][W-1:0]   integ;
        logic [CH-1:0][STAGES-1:0][W-1:0]   cd;
        logic [CH-1:0][DOUT_W-1:0]          res;
        logic [CH-1:0]                      pend;
        logic [DOUT_W*OUT_LANES-1:0]        dout;
        logic [OUT_LANES-1:0]               vld;
    } cicr_reg_t;

    cicr_reg_t   r_q;
    cicr_reg_t   r_d;
    logic [W-1:0] x;
    logic [W-1:0] y;
    logic [W-1:0] t;
    logic [CW-1:0] s;
    logic        acc;
    logic        tick;
    logic        dump;
    int          c;

    // ==================================================================
    // Next state
    always_comb
    begin
        r_d  = r_q;
        x    = '0;
        y    = '0;
        t    = '0;
        c    = 0;
        s    = first_slot_mark_in ? '0 : r_q.ch;
        acc  = 1'b0;
        tick = 1'b0;
        dump = (r_q.phase == r_q.rate - RATE_W'(1));
        r_d.early = 1'b0;
        r_d.vld   = '0;
        if (r_q.st == CICR_ST_CLEAR)
        begin
            if (USE_MEM)
            begin
                if (int'(r_q.clr) < CH)
                begin
                    r_d.integ[r_q.clr] = '0;
                    r_d.cd[r_q.clr]    = '0;
                    r_d.pend[r_q.clr]  = 1'b0;
                end
            end
            else
            begin
                r_d.integ = '0;
                r_d.cd    = '0;
                r_d.pend  = '0;
            end
            r_d.clr = r_q.clr + CLR_W'(1);
            if (r_q.clr == CLR_LAST)
            begin
                r_d.st    = CICR_ST_RUN;
                r_d.clr   = '0;
                r_d.phase = '0;
                r_d.ch    = '0;
                r_d.ptr   = '0;
                // early pulse ahead of the first ready
                r_d.early = IS_INT && (USE_EARLY_READY == 1);
                // decimator ready once clear is over
                r_d.ready = !IS_INT;
            end
        end
        else if (!IS_INT)
        begin
            // Output scanner serialises finished channels
            r_d.ptr = (int'(r_q.ptr) == CH - 1) ? '0 : r_q.ptr + CW'(1);
            if (r_q.pend[r_q.ptr])
            begin
                r_d.dout         = r_q.res[r_q.ptr];
                r_d.vld[0]       = 1'b1;
                r_d.pend[r_q.ptr] = 1'b0;
            end
            acc = r_q.ready && (din_strobe || (USE_STROBE == 0));
            if (acc)
            begin
                for (int i = 0; i < IF_NUM; i++)
                begin
                    c = i * SLOTS + int'(s);
                    x = {{(W-DIN_W){din[i*DIN_W+DIN_W-1]}}, din[i*DIN_W +: DIN_W]};
                    for (int k = 0; k < STAGES; k++)
                    begin
                        r_d.integ[c][k] = r_q.integ[c][k] + ((k == 0) ? x : r_q.integ[c][(k>0)?k-1:0]);
                    end
                    if (dump)
                    begin
                        y = r_d.integ[c][STAGES-1];
                        for (int k = 0; k < STAGES; k++)
                        begin
                            t = y - r_q.cd[c][k];
                            r_d.cd[c][k] = y;
                            y = t;
                        end
                        r_d.res[c]  = y[W-1 -: DOUT_W];
                        r_d.pend[c] = 1'b1;
                    end
                end
                if (int'(s) == SLOTS - 1)
                begin
                    r_d.ch    = '0;
                    r_d.phase = dump ? '0 : r_q.phase + RATE_W'(1);
                    // Scanner restarts so channel 0 leads the burst
                    r_d.ptr   = dump ? '0 : r_d.ptr;
                end
                else
                begin
                    r_d.ch = s + CW'(1);
                end
            end
        end
        else
        begin
            // strobe with first-slot mark opens the frame
            tick = din_strobe && (first_slot_mark_in || r_q.ch != '0);
            if (tick)
            begin
                c = int'(s);
                if (r_q.ready)
                begin
                    y = {{(W-DIN_W){din[DIN_W-1]}}, din[DIN_W-1:0]};
                    for (int k = 0; k < STAGES; k++)
                    begin
                        t = y - r_q.cd[c][k];
                        r_d.cd[c][k] = y;
                        y = t;
                    end
                    x = y;
                end
                for (int k = 0; k < STAGES; k++)
                begin
                    r_d.integ[c][k] = r_q.integ[c][k] + ((k == 0) ? x : r_q.integ[c][(k>0)?k-1:0]);
                end
                r_d.dout[(c / SLOTS)*DOUT_W +: DOUT_W] = r_d.integ[c][STAGES-1][W-1 -: DOUT_W];
                r_d.vld[c / SLOTS] = 1'b1;
                if (c == CH - 1)
                begin
                    r_d.ch = '0;
                    if (dump)
                    begin
                        r_d.phase = '0;
                        // early pulse, ready follows next cycle
                        r_d.early = (USE_EARLY_READY == 1);
                        r_d.ready = (USE_EARLY_READY == 0);
                    end
                    else
                    begin
                        r_d.phase = r_q.phase + RATE_W'(1);
                        // ready only during the input frame
                        if (r_q.phase == '0)
                        begin
                            r_d.ready = 1'b0;
                        end
                    end
                end
                else
                begin
                    r_d.ch = CW'(c + 1);
                end
            end
        end
        // ready rises after the early pulse
        if (IS_INT && r_q.early)
        begin
            r_d.ready = 1'b1;
        end
        // rate port honoured only for variable rate
        if (VAR_RATE == 1 && rate_cfg.we)
        begin
            r_d.rate_new = rate_cfg.value;
        end
        // new rate applied by sync reset
        if (sync_rst)
        begin
            r_d.st    = CICR_ST_CLEAR;
            r_d.clr   = '0;
            r_d.ready = 1'b0;
            r_d.early = 1'b0;
            r_d.vld   = '0;
            r_d.rate  = (VAR_RATE == 1) ? r_q.rate_new : RATE_RST;
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_q          <= '0;
            r_q.st       <= CICR_ST_CLEAR;
            r_q.rate     <= RATE_RST;
            r_q.rate_new <= RATE_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign source_ready      = r_q.ready;
    assign ready_early_pulse = r_q.early;
    assign dout              = r_q.dout;
    assign dout_valid        = r_q.vld;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_clear_not_ready;
        (r_q.st == CICR_ST_CLEAR) |-> !source_ready;
    endproperty
    a_clear_not_ready: assert property (p_clear_not_ready) else $error("ready high during clear");

    property p_dec_ready_run;
        (!IS_INT && r_q.st == CICR_ST_RUN && !sync_rst) |=> source_ready;
    endproperty
    a_dec_ready_run: assert property (p_dec_ready_run) else $error("decimator ready dropped in run");

    property p_early_then_ready;
        (ready_early_pulse && !sync_rst) |=> (source_ready && !ready_early_pulse);
    endproperty
    a_early_then_ready: assert property (p_early_then_ready) else $error("ready missing after early pulse");

    property p_no_early_dec;
        !IS_INT |-> !ready_early_pulse;
    endproperty
    a_no_early_dec: assert property (p_no_early_dec) else $error("early pulse in decimator");

    property p_rate_capture;
        (VAR_RATE == 1 && rate_cfg.we) |=> (r_q.rate_new == $past(rate_cfg.value));
    endproperty
    a_rate_capture: assert property (p_rate_capture) else $error("rate write not captured");

    property p_rate_hold;
        (rate_cfg.we && !sync_rst) |=> $stable(r_q.rate);
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("active rate changed without reset");

    property p_rate_apply;
        sync_rst |=> (r_q.rate == ((VAR_RATE == 1) ? $past(r_q.rate_new) : RATE_RST));
    endproperty
    a_rate_apply: assert property (p_rate_apply) else $error("rate not applied on reset");

    property p_int_no_mark;
        (IS_INT && r_q.st == CICR_ST_RUN && din_strobe && !first_slot_mark_in && r_q.ch == '0 && !sync_rst)
            |=> (dout_valid == '0);
    endproperty
    a_int_no_mark: assert property (p_int_no_mark) else $error("unmarked strobe accepted");

    property p_int_tick_out;
        (IS_INT && r_q.st == CICR_ST_RUN && din_strobe && first_slot_mark_in && !sync_rst) |=> (dout_valid != '0);
    endproperty
    a_int_tick_out: assert property (p_int_tick_out) else $error("no output for strobe");

    property p_clear_ends;
        $rose(r_q.st == CICR_ST_CLEAR) ##0 !sync_rst [*2] |-> ##[0:CLR_LEN] ((r_q.st == CICR_ST_RUN) || sync_rst);
    endproperty
    a_clear_ends: assert property (p_clear_ends) else $error("clear did not finish");

    c_dec_out: cover property (!IS_INT && dout_valid != '0);
    c_int_ready: cover property (IS_INT && $rose(source_ready));
    c_rate_reload: cover property (rate_cfg.we ##[1:20] sync_rst);

endmodule

`default_nettype wire

/* File: dv/cicr_src_model.sv */
// Upstream sample source that feeds the CIC interpolator, one channel per strobe.
// Assumes the filter samples its inputs on the rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none

module cicr_src_model
#(
    parameter int DIN_W   = 8,
    parameter int CH      = 2,
    parameter int SPACING = 3
)
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    // Scenario controls
    input  wire logic [DIN_W*CH-1:0] chan_val,
    input  wire logic                skip_mark,
    // Filter side
    input  wire logic                source_ready,
    output logic                     din_strobe,
    output logic                     first_slot_mark_in,
    output logic [7:0]               chan,
    output logic [DIN_W-1:0]         din
);
    int               gap;
    logic             started;
    logic [DIN_W-1:0] word;

    assign word = chan_val[chan*DIN_W +: DIN_W];
    // Garbage unless a strobe meets a ready filter
    assign din = (din_strobe && source_ready) ? word : ~word;

    // ==================================================================
    // Strobe pacing
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gap                <= 0;
            started            <= 1'b0;
            din_strobe         <= 1'b0;
            first_slot_mark_in <= 1'b0;
            chan               <= '0;
        end
        else
        begin
            started <= started | source_ready;
            gap     <= (gap == SPACING - 1 || !started) ? 0 : gap + 1;
            din_strobe <= started && gap == SPACING - 1;
            first_slot_mark_in <= started && gap == SPACING - 1 && chan == 0 && !skip_mark;
            // Channel moves on only after a strobe the filter keeps
            if (din_strobe && (first_slot_mark_in || chan != 0))
                chan <= (chan == CH - 1) ? '0 : chan + 8'h01;
        end
    end
endmodule

`default_nettype wire

/* File: dv/cicr_filter_tb.sv */
// Self-checking bench: a two-interface decimator and a two-interface interpolator.
// Assumes cicr_pkg and cicr_src_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CICR_CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module cicr_filter_tb;
    import cicr_pkg::*;
    localparam int NST   = STAGES_DEF;
    localparam int ISKIP = 32;
    localparam int SP    = 3;
    localparam int IR    = 4;
    localparam int NIF   = 2;
    localparam int NSL   = 1;
    localparam int DW    = 8;
    localparam int DOW   = 20;
    localparam int IOW   = 16;
    localparam int DR    = 4;
    localparam int DRMAX = 8;
    localparam int VR_ON = 1;
    localparam int VR_NO = 0;
    logic           core_clk;
    logic           rst_b;
    logic           sync_rst;
    logic [15:0]    d_din;
    logic           d_strobe;
    logic           d_ready;
    logic [19:0]    d_dout;
    logic [0:0]     d_valid;
    cicr_rate_cfg_t rate_cfg;
    logic [7:0]     i_din;
    logic           i_strobe;
    logic           i_mark;
    logic           i_ready;
    logic           i_early;
    logic [31:0]    i_dout;
    logic [1:0]     i_valid;
    logic [1:0]     iv_exp;
    logic [15:0]    iexp;
    logic [7:0]     chan;
    logic [15:0]    chan_val;
    logic           skip_mark;
    logic           dec_live;
    logic           prev_rdy;
    logic           prev_early;
    logic [19:0]    dq;
    logic [19:0]    q[$];
    logic [31:0]    seed;
    int             dx[2];
    int             icnt[2]  = '{0, 0};
    int             ilast[2] = '{0, 0};
    int             dskip     = 0;
    int             cyc       = 0;
    int             bad_count = 0;
    int             compares  = 0;

    // single slot: the mark copies the strobe
    cicr_filter #(.FILTER_DIRECTION(DIR_DECIMATE), .IF_NUM(NIF), .SLOTS(NSL), .DIN_W(DW), .DOUT_W(DOW),
        .R_RATE(DR), .VAR_RATE(VR_ON), .VAR_R_MAX(DRMAX)) i_cicr_filter
    (
        .core_clk(core_clk), .rst_b(rst_b), .sync_rst(sync_rst), .din(d_din), .din_strobe(d_strobe),
        .first_slot_mark_in(d_strobe), .source_ready(d_ready), .ready_early_pulse(),
        .dout(d_dout), .dout_valid(d_valid), .rate_cfg(rate_cfg)
    );
    cicr_filter #(.FILTER_DIRECTION(DIR_INTERPOLATE), .IF_NUM(NIF), .SLOTS(NSL), .DIN_W(DW), .DOUT_W(IOW),
        .R_RATE(IR), .VAR_RATE(VR_NO), .VAR_R_MAX(IR)) i_cicr_filter_interp
    (
        .core_clk(core_clk), .rst_b(rst_b), .sync_rst(1'b0), .din(i_din), .din_strobe(i_strobe),
        .first_slot_mark_in(i_mark), .source_ready(i_ready), .ready_early_pulse(i_early),
        .dout(i_dout), .dout_valid(i_valid), .rate_cfg(rate_cfg)
    );
    cicr_src_model #(.DIN_W(DW), .CH(NIF), .SPACING(SP)) i_cicr_src_model
    (
        .core_clk(core_clk), .rst_b(rst_b), .chan_val(chan_val), .skip_mark(skip_mark),
        .source_ready(i_ready), .din_strobe(i_strobe), .first_slot_mark_in(i_mark),
        .chan(chan), .din(i_din)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic print_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==================================================================
    // Decimator traffic with random gaps; garbage rides the idle cycles
    task automatic dec_run(input int rate, input int blocks);
        int   n;
        int   b;
        logic s;
        n = 0;
        b = 0;
        dskip = 2 * (NST + 1);
        dec_live = 1'b1;
        while (b < blocks)
        begin
            @(posedge core_clk);
            s = (rnd() % 4) != 0;
            d_strobe <= s;
            if (s)
                d_din <= {8'(dx[1]), 8'(dx[0])};
            else
                d_din <= 16'(rnd());
            n = n + int'(s);
            if (n == rate)
            begin
                n = 0;
                b++;
                if (b > NST + 1)
                begin
                    q.push_back(20'(dx[0] * rate ** NST));
                    q.push_back(20'(dx[1] * rate ** NST));
                end
            end
        end
        @(posedge core_clk);
        d_strobe <= 1'b0;
        repeat (60) @(posedge core_clk);
        dec_live = 1'b0;
        `CICR_CHK("dec outputs left", 0, q.size())
    endtask

    // Sync reset, with a sample offered while ready is low
    task automatic sync_pulse();
        @(posedge core_clk);
        sync_rst <= 1'b1;
        @(posedge core_clk);
        sync_rst <= 1'b0;
        d_strobe <= 1'b1;
        d_din    <= 16'(rnd());
        @(negedge core_clk);
        `CICR_CHK("ready in clear", 1'b0, d_ready)
        @(posedge core_clk);
        d_strobe <= 1'b0;
        @(negedge core_clk);
        `CICR_CHK("ready after clear", 1'b1, d_ready)
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) cyc <= cyc + 1;

    // ==================================================================
    // Decimator output watcher
    always @(negedge core_clk)
    begin
        if (rst_b && d_valid === 1'b1)
        begin
            if (dskip > 0)
                dskip--;
            else
            begin
                dq = (q.size() > 0) ? q.pop_front() : 20'hxxxxx;
                `CICR_CHK("dec sample", dq, d_dout)
            end
        end
        if (dec_live)
            `CICR_CHK("dec ready", 1'b1, d_ready)
    end

    // ==================================================================
    // Interpolator output watcher
    always @(negedge core_clk)
    begin
        if (!rst_b)
        begin
            iv_exp     = 2'b00;
            prev_rdy   = 1'b0;
            prev_early = 1'b0;
        end
        else
        begin
            `CICR_CHK("interp valid", iv_exp, i_valid)
            for (int l = 0; l < 2; l++)
            begin
                if (i_valid[l] === 1'b1)
                begin
                    icnt[l]++;
                    if (icnt[l] > ISKIP)
                    begin
                        iexp = 16'($signed(chan_val[l*8 +: 8]) * IR ** (NST - 1));
                        `CICR_CHK("interp sample", iexp, i_dout[l*16 +: 16])
                        `CICR_CHK("interp spacing", 2 * SP, cyc - ilast[l])
                    end
                    ilast[l] = cyc;
                end
            end
            iv_exp = (i_strobe && (i_mark || chan != 8'h00)) ? 2'(2'b01 << chan) : 2'b00;
            if (i_ready === 1'b1 && !prev_rdy)
                `CICR_CHK("early before ready", 1'b1, prev_early)
            if (i_early === 1'b1)
                `CICR_CHK("early width", 1'b0, prev_early)
            prev_rdy   = i_ready;
            prev_early = i_early;
        end
    end

    // First channel-zero strobe goes out without its mark
    initial
    begin
        @(posedge i_strobe);
        @(posedge core_clk);
        skip_mark <= 1'b0;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        print_verdict();
    end

    initial
    begin
        seed      = 32'hdb9864a1;
        rst_b     = 1'b0;
        sync_rst  = 1'b0;
        d_din     = 16'h0000;
        d_strobe  = 1'b0;
        rate_cfg  = '0;
        skip_mark = 1'b1;
        dec_live  = 1'b0;
        for (int k = 0; k < 2; k++)
            dx[k] = int'(rnd() % 201) - 100;
        chan_val = {8'(int'(rnd() % 201) - 100), 8'(int'(rnd() % 201) - 100)};
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        // capture on the write pulse only
        rate_cfg <= '{we: 1'b1, value: 11'h008};
        @(posedge core_clk);
        rate_cfg <= '{we: 1'b0, value: 11'h003};
        dec_run(4, 12);
        sync_pulse();
        dec_run(8, 10);
        for (int k = 0; k < 4000 && icnt[1] <= ISKIP + 20; k++)
            @(posedge core_clk);
        `CICR_CHK("interp lanes ran", 1'b1, icnt[1] > ISKIP + 20)
        print_verdict();
    end
endmodule

`default_nettype wire
